// >>> core/tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// File address of the counter register.
`define TIMER_COUNT_ADDR   5'h01
`define CTRL_RESET         8'h3f
`define CTRL_CS_BIT        5
`define CTRL_SE_BIT        4
`define CTRL_PA_BIT        3
`define CTRL_PS_MSB        2
`define CTRL_PS_LSB        0
`define WRITE_HOLD_CYCLES  2'h2

`endif

// >>> core/tmr_pkg.sv
package tmr_pkg;
	typedef enum logic {
		PRE_TO_TIMER,
		PRE_TO_WATCHDOG
	} pre_owner_t;
endpackage

// >>> core/pre_tap_select.sv
`include "tmr_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Picks the prescaler tap for the chosen ratio and reports its falling edge.
module pre_tap_select #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pre_count,
	input  wire logic [2:0]       tap,
	output logic                  tap_rise
);
	logic tap_now;
	logic tap_r;

	if (WIDTH != 8) begin : g_width_check
		$error("pre_tap_select: WIDTH must be 8");
	end

	assign tap_now = pre_count[tap];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tap_r <= 1'b0;
		end else begin
			tap_r <= tap_now;
		end
	end

	// A falling tap bit is a carry out of the selected stage.
	assign tap_rise = tap_r & ~tap_now;
endmodule // pre_tap_select

// >>> core/ext_edge_sync.sv
////////////////////////////////////////////////////////////////////////////////
// Samples the external count path twice per instruction cycle and pulses on
// the selected edge, at the next sample strobe after it is seen.
module ext_edge_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic phase_two,
	input  wire logic phase_four,
	input  wire logic level_in,
	input  wire logic falling,
	output logic      edge_pulse
);
	logic samp_r;
	logic prev_r;
	logic hit_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			samp_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (phase_two | phase_four) begin
			samp_r <= level_in;
			prev_r <= samp_r;
		end
	end

	// Registered edge gives the short delay after synchronisation.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= (phase_two | phase_four) &
			         (falling ? (prev_r & ~samp_r) : (~prev_r & samp_r));
		end
	end

	assign edge_pulse = hit_r;
endmodule // ext_edge_sync

// >>> core/timer_counter_prescaler.sv
//Contract
//- Eight-bit counter, read and written by core.
//- Timer mode counts each instruction cycle.
//- Write suppresses counting for two cycles.
//- Counter mode counts external input edges.
//- Edge bit: zero rising, one falling.
//- Assign bit: zero timer, one watchdog.
//- One prescaler user; other runs undivided.
//- Timer ratios 1:2 through 1:256.
//- Prescaler count hidden from software.
//- Counter writes clear timer-owned prescaler.
//- Watchdog clear clears watchdog-owned prescaler.
//- Reset zeroes the prescaler.
//- Sample external path at phases two, four.
//- External prescaling is a ripple divider; here a synchronous counter.
//- Increment lands shortly after synchronised edge.
//- Counter survives master clear and watchdog reset.
//- Watchdog ratios up to 1:128.
//- Sleep clears watchdog, and owned prescaler.
`include "tmr_defines.svh"
module timer_counter_prescaler #(
	parameter int PRE_WIDTH = 8
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       phase_two,
	input  wire logic       phase_four,
	input  wire logic       instr_tick,
	input  wire logic [4:0] file_addr,
	input  wire logic       file_wr,
	input  wire logic [7:0] file_wdata,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic       watchdog_clear_op,
	input  wire logic       sleep_op,
	input  wire logic       ext_count_input,
	input  wire logic       watchdog_tick,
	output logic [7:0]      timer_count,
	output logic            watchdog_count_pulse,
	output logic            watchdog_clear
);
	// The phase strobes and the instruction tick come from the core's clock
	// sequencer; every rate in the block is one of these strobes, the watchdog
	// tick or a carry of the prescaler, all on the single system clock.
	logic [7:0]           ctrl_r;
	logic [7:0]           count_r;
	logic [7:0]           count_nxt;
	logic [PRE_WIDTH-1:0] pre_r;
	logic [1:0]           hold_r;
	logic                 wdog_pulse_r;
	logic                 wdog_clr_r;
	tmr_pkg::pre_owner_t  owner;
	logic                 clock_source_select;
	logic                 source_edge_select;
	logic [2:0]           prescale_select;
	logic                 cnt_wr;
	logic                 ext_pulse;
	logic                 base_pulse;
	logic                 pre_in;
	logic                 pre_clr;
	logic [2:0]           tap;
	logic                 tap_rise;
	logic                 pre_out_level;
	logic                 timer_inc;
	logic [PRE_WIDTH-1:0] pre_nxt;
	logic [1:0]           hold_nxt;
	logic [7:0]           ctrl_nxt;
	logic [2:0]           timer_tap;
	logic [2:0]           wdog_tap;
	logic [2:0]           tap_q_r;
	logic                 pre_step_r;
	logic                 carry;
	logic                 wdog_nxt;
	logic                 timer_owned;
	logic                 wdog_owned;

	// The tap decode and the field slices below are written for these sizes.
	if (PRE_WIDTH != 8) begin : g_width_check
		$error("timer_counter_prescaler: PRE_WIDTH must be 8");
	end
	if (`CTRL_PS_MSB - `CTRL_PS_LSB != 2) begin : g_field_check
		$error("timer_counter_prescaler: prescale field must be three bits");
	end
	if (`WRITE_HOLD_CYCLES == 2'h0) begin : g_hold_check
		$error("timer_counter_prescaler: write hold must be nonzero");
	end

	////////////////////////////////////////////////////////////////////////////
	// Control word decode.
	// Field positions live in the defines header; the reset value selects
	// counter mode, falling edges and the prescaler on the watchdog at 1:128.
	assign clock_source_select = ctrl_r[`CTRL_CS_BIT];
	assign source_edge_select  = ctrl_r[`CTRL_SE_BIT];
	assign prescale_select     = ctrl_r[`CTRL_PS_MSB:`CTRL_PS_LSB];
	assign owner = ctrl_r[`CTRL_PA_BIT] ? tmr_pkg::PRE_TO_WATCHDOG
	                                    : tmr_pkg::PRE_TO_TIMER;
	assign cnt_wr = file_wr & (file_addr == `TIMER_COUNT_ADDR);
	assign timer_owned = (owner == tmr_pkg::PRE_TO_TIMER);
	assign wdog_owned  = (owner == tmr_pkg::PRE_TO_WATCHDOG);

	// The control word is write-only: it feeds the decode and nothing reads it.
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = ctrl_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_r <= `CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// External path. The pin is sampled at phases two and four and the chosen
	// edge becomes a one-cycle pulse; in counter mode that pulse, not the raw
	// pin, steps the prescaler, or the counter when the watchdog owns the prescaler. Inputs are synchronous here, so the
	// divider may sit after the sampler without losing edges, as long as the
	// source keeps each level for two clocks or more. A faster source needs a
	// true ripple stage on the pin side, which this block does not provide.
	ext_edge_sync u_sync (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.phase_two  (phase_two),
		.phase_four (phase_four),
		.level_in   (ext_count_input),
		.falling    (source_edge_select),
		.edge_pulse (ext_pulse)
	);

	// Timer mode counts instruction ticks, counter mode the external pulse.
	always_comb begin
		base_pulse = instr_tick;
		if (clock_source_select) begin
			base_pulse = ext_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler. Its owner decides both what steps it and what clears it.
	always_comb begin
		unique case (owner)
			tmr_pkg::PRE_TO_TIMER: begin
				pre_in  = base_pulse;
				pre_clr = cnt_wr;
			end
			tmr_pkg::PRE_TO_WATCHDOG: begin
				pre_in  = watchdog_tick;
				pre_clr = watchdog_clear_op | sleep_op;
			end
		endcase
	end

	// Synchronous stand-in for the ripple divider: each bit is a symmetric
	// half-rate of the one below it.
	always_comb begin
		pre_nxt = pre_r;
		if (pre_clr) begin
			pre_nxt = '0;
		end else if (pre_in) begin
			pre_nxt = pre_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_nxt;
		end
	end

	// Marks a cycle in which the prescaler has just stepped. A clear also
	// drops the tap bit, and that fall must not pass for a carry.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_step_r <= 1'b0;
		end else begin
			pre_step_r <= pre_in & ~pre_clr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tap and carry.

	// Timer ratio 2^(n+1) is the carry out of bit n.
	always_comb begin
		unique case (prescale_select)
			3'h0: timer_tap = 3'h0;
			3'h1: timer_tap = 3'h1;
			3'h2: timer_tap = 3'h2;
			3'h3: timer_tap = 3'h3;
			3'h4: timer_tap = 3'h4;
			3'h5: timer_tap = 3'h5;
			3'h6: timer_tap = 3'h6;
			3'h7: timer_tap = 3'h7;
		endcase
	end

	// Watchdog ratio 2^n is the carry out of bit n-1. A zero field bypasses
	// the divider, so its tap is never used and is parked on bit zero.
	always_comb begin
		unique case (prescale_select)
			3'h0: wdog_tap = 3'h0;
			3'h1: wdog_tap = 3'h0;
			3'h2: wdog_tap = 3'h1;
			3'h3: wdog_tap = 3'h2;
			3'h4: wdog_tap = 3'h3;
			3'h5: wdog_tap = 3'h4;
			3'h6: wdog_tap = 3'h5;
			3'h7: wdog_tap = 3'h6;
		endcase
	end

	always_comb begin
		unique case (owner)
			tmr_pkg::PRE_TO_TIMER:    tap = timer_tap;
			tmr_pkg::PRE_TO_WATCHDOG: tap = wdog_tap;
		endcase
	end

	// The tap stage registers the chosen bit and flags its fall.
	pre_tap_select #(
		.WIDTH (PRE_WIDTH)
	) u_tap (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.pre_count (pre_r),
		.tap       (tap),
		.tap_rise  (tap_rise)
	);

	// Remembers the tap in use, so that a control write moving the tap cannot
	// turn the difference between two prescaler bits into a false carry.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tap_q_r <= 3'h0;
		end else begin
			tap_q_r <= tap;
		end
	end

	assign carry         = tap_rise & pre_step_r & (tap == tap_q_r);
	assign pre_out_level = carry;

	////////////////////////////////////////////////////////////////////////////
	// Counter increment source.
	// With the prescaler elsewhere the counter takes the undivided source.
	always_comb begin
		unique case (owner)
			tmr_pkg::PRE_TO_TIMER: begin
				timer_inc = pre_out_level;
			end
			tmr_pkg::PRE_TO_WATCHDOG: begin
				timer_inc = base_pulse;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog side.

	// Watchdog gets its undivided tick unless it owns the prescaler with a
	// nonzero ratio field.
	always_comb begin
		wdog_nxt = watchdog_tick;
		if (wdog_owned && prescale_select != 3'h0) begin
			wdog_nxt = carry;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wdog_pulse_r <= 1'b0;
		end else begin
			wdog_pulse_r <= wdog_nxt;
		end
	end

	// Clear and sleep both restart the watchdog one cycle after the request,
	// whoever owns the prescaler.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wdog_clr_r <= 1'b0;
		end else begin
			wdog_clr_r <= watchdog_clear_op | sleep_op;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write inhibit: two instruction cycles without counting after a write.
	// The hold counts instruction ticks, not clocks, so it spans the same
	// time in timer and counter mode.
	always_comb begin
		hold_nxt = hold_r;
		if (cnt_wr) begin
			hold_nxt = `WRITE_HOLD_CYCLES;
		end else if (instr_tick && hold_r != 2'h0) begin
			hold_nxt = hold_r - 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hold_r <= 2'h0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter register.

	// A write takes priority over an increment that falls in the same cycle;
	// the increment is lost, which the write inhibit would suppress anyway.
	always_comb begin
		count_nxt = count_r;
		if (cnt_wr) begin
			count_nxt = file_wdata;
		end else if (timer_inc && hold_r == 2'h0) begin
			count_nxt = count_r + 8'h01;
		end
	end

	// No reset term: the count keeps its value through every reset.
	always_ff @(posedge sys_clk) begin
		count_r <= count_nxt;
	end

	// The count output is the register itself; the prescaler has no port.
	assign timer_count          = count_r;
	assign watchdog_count_pulse = wdog_pulse_r;
	assign watchdog_clear       = wdog_clr_r;
endmodule // timer_counter_prescaler

// >>> test/core_phase_model.sv
module core_phase_model (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	output logic      phase_two,
	output logic      phase_four,
	output logic      instr_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] q_r = 2'h0;
	// Four phase clocks form one instruction cycle, moved off the sampling edge.
	always @(negedge sys_clk) begin
		q_r <= sys_rst ? 2'h0 : q_r + 2'h1;
	end
	assign phase_two  = q_r == 2'h1;
	assign phase_four = q_r == 2'h3;
	assign instr_tick = q_r == 2'h3;
endmodule // core_phase_model

// >>> test/tcp_assertions.sv
module tcp_assertions (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       instr_tick,
	input wire logic [4:0] file_addr,
	input wire logic       file_wr,
	input wire logic [7:0] file_wdata,
	input wire logic       ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic       watchdog_clear_op,
	input wire logic       sleep_op,
	input wire logic       ext_count_input,
	input wire logic       watchdog_tick,
	input wire logic [7:0] timer_count,
	input wire logic       watchdog_count_pulse,
	input wire logic       watchdog_clear
);
	logic [7:0] ctrl_r;
	logic [3:0] quiet_r;
	logic       ext_r;
	logic       wr;
	logic       seen_r;
	assign wr = file_wr && file_addr == 5'h01;
	// The count is unknown until the first write after power-up.
	always_ff @(posedge sys_clk) begin
		seen_r <= !sys_rst && (seen_r || wr);
	end
	// Shadows the write-only control word and counts cycles with no external activity.
	always_ff @(posedge sys_clk) begin
		ctrl_r <= sys_rst ? 8'h3f : ctrl_wr ? ctrl_wdata : ctrl_r;
	end
	always_ff @(posedge sys_clk) begin
		ext_r <= ext_count_input;
		quiet_r <= (sys_rst || ctrl_wr || ext_r != ext_count_input) ? 4'h0 :
			quiet_r + {3'h0, quiet_r != 4'hf};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_write_load: assert property (
		wr |=> timer_count == $past(file_wdata)) else $error("load");
	chk_write_hold: assert property (
		wr ##1 !wr |=> $stable(timer_count)) else $error("hold");
	chk_step_one: assert property (
		!$past(wr) && !$stable(timer_count) |-> timer_count == $past(timer_count) + 8'h01)
		else $error("step");
	chk_timer_pace: assert property (
		!ctrl_r[5] && !$past(wr) && !$stable(timer_count)
		|-> $past(instr_tick) || $past(instr_tick, 2)) else $error("pace");
	chk_ext_quiet: assert property (
		seen_r && ctrl_r[5] && quiet_r > 4'h8 && !$past(wr) |-> $stable(timer_count))
		else $error("quiet");
	chk_wd_pass: assert property (
		(!ctrl_r[3] || ctrl_r[2:0] == 3'h0) && watchdog_tick |=> watchdog_count_pulse)
		else $error("pass");
	chk_wd_cause: assert property (
		watchdog_count_pulse |-> $past(watchdog_tick) || $past(watchdog_tick, 2))
		else $error("cause");
	chk_clear_op: assert property (
		watchdog_clear_op || sleep_op |=> watchdog_clear) else $error("clear");
endmodule // tcp_assertions

bind timer_counter_prescaler tcp_assertions chk (.*);

// >>> test/timer_counter_prescaler_tb.sv
`define CHK(n, e, a) n_tests++; \
	if ((a) !== (e)) begin bad_count++; $display("ERROR %s expected %h seen %h", n, e, a); end
module timer_counter_prescaler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0, sys_rst = 1'b1, file_wr = 1'b0, ctrl_wr = 1'b0;
	logic       wd_clr = 1'b0, sleep_op = 1'b0, ext_in = 1'b0, wd_tick = 1'b0;
	logic       phase_two, phase_four, instr_tick, wd_pulse, wd_clear;
	logic [4:0] file_addr = 5'h01;
	logic [7:0] file_wdata = 8'h00, ctrl_wdata = 8'h00, timer_count, a;
	int         bad_count = 0, n_tests = 0, wd_seen = 0;
	core_phase_model core (.sys_clk, .sys_rst, .phase_two, .phase_four, .instr_tick);
	timer_counter_prescaler dut (.sys_clk, .sys_rst, .phase_two, .phase_four, .instr_tick,
		.file_addr, .file_wr, .file_wdata, .ctrl_wr, .ctrl_wdata, .watchdog_clear_op(wd_clr),
		.sleep_op, .ext_count_input(ext_in), .watchdog_tick(wd_tick), .timer_count,
		.watchdog_count_pulse(wd_pulse), .watchdog_clear(wd_clear));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (wd_pulse === 1'b1) wd_seen++;
	end
	task automatic wr(input logic [4:0] ad, input logic [7:0] d);
		@(posedge sys_clk iff instr_tick);
		@(negedge sys_clk);
		file_addr = ad;
		file_wdata = d;
		file_wr = 1'b1;
		@(negedge sys_clk);
		file_wr = 1'b0;
	endtask
	task automatic ctl(input logic [7:0] d);
		@(negedge sys_clk);
		ctrl_wdata = d;
		ctrl_wr = 1'b1;
		@(negedge sys_clk);
		ctrl_wr = 1'b0;
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic pulse(input bit slp);
		@(negedge sys_clk);
		if (slp) sleep_op = 1'b1; else wd_clr = 1'b1;
		@(negedge sys_clk);
		sleep_op = 1'b0;
		wd_clr = 1'b0;
		`CHK("wd clear", 1'b1, wd_clear)
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk iff instr_tick);
		repeat (3) @(negedge sys_clk);
	endtask
	// Each level of the external input lasts four clocks.
	task automatic tog(input int n);
		repeat (n) begin
			repeat (4) @(negedge sys_clk);
			ext_in = ~ext_in;
		end
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic wdt(input int n);
		wd_seen = 0;
		repeat (n) begin
			@(negedge sys_clk);
			wd_tick = 1'b1;
			@(negedge sys_clk);
			wd_tick = 1'b0;
		end
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		ctl(8'h08);
		wr(5'h01, 8'hfe);
		`CHK("load", 8'hfe, timer_count)
		tk(2);
		`CHK("held", 8'hfe, timer_count)
		tk(4);
		`CHK("wrap", 8'h02, timer_count)
		ctl(8'h0a);
		pulse(1'b0);
		wdt(8);
		`CHK("wd ratio", 2, wd_seen)
		pulse(1'b1);
		pulse(1'b0);
		for (int p = 0; p < 8; p++) begin
			ctl({5'h00, p[2:0]});
			wr(5'h01, 8'h00);
			tk(8);
			a = timer_count;
			tk(4 << p);
			`CHK("ratio", a + 8'h02, timer_count)
		end
		wdt(3);
		`CHK("wd undivided", 3, wd_seen)
		pulse(1'b0);
		wr(5'h01, 8'h00);
		ctl(8'h28);
		tog(3);
		`CHK("rising", 8'h02, timer_count)
		ctl(8'h38);
		wr(5'h01, 8'h00);
		tog(1);
		`CHK("falling", 8'h01, timer_count)
		wr(5'h01, 8'h5a);
		sys_rst = 1'b1;
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		`CHK("kept", 8'h5a, timer_count)
		wr(5'h02, 8'h33);
		`CHK("unmapped", 8'h5a, timer_count)
		summarize();
	end
endmodule // timer_counter_prescaler_tb
